// ### hdl/pio_pkg.sv
// package: register map, field layout and timing for the parallel handshake port
package pio_pkg;
	localparam int unsigned ADDR_W = 8;
	// register byte addresses
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PORTC_LATCH = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PORTB = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PORTC = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_PORTC_DIR = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h14;
	// control register fields
	localparam int unsigned BIT_FLAG = 7;
	localparam int unsigned BIT_IRQEN = 6;
	localparam int unsigned BIT_ODRAIN = 5;
	localparam int unsigned BIT_FULL_HANDSHAKE_SELECT = 4;
	localparam int unsigned BIT_DIR = 3;
	localparam int unsigned BIT_PULSE = 2;
	localparam int unsigned BIT_EDGE = 1;
	localparam int unsigned BIT_POL = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h7f;
	// mode register fields
	localparam int unsigned BIT_SINGLE = 0;
	localparam int unsigned BIT_CCR_I = 1;
	localparam logic [1:0] MODE_RESET = 2'h3;
	// strobe B pulse length
	localparam int unsigned PULSE_NS = 100;
	localparam int unsigned CLK_NS = 50;
	localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// port C pin bundle
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} portc_pins_s;
endpackage : pio_pkg

// ### hdl/strobe_sync.sv
// strobe A synchroniser and active-edge detector
`timescale 1ns/100ps
`default_nettype none
module strobe_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// raw pin and edge choice
	input wire logic strobeAPin,
	input wire logic riseSel,
	// synchronised level and edge pulse
	output logic level,
	output logic edgeSeen
);
	typedef struct packed {
		logic [2:0] sync;
		logic stable;
	} sync_s;
	sync_s q, d;

	// change counts once the second and third stage agree
	always_comb begin
		d = q;
		d.sync = {q.sync[1:0], strobeAPin};
		if (q.sync[2] == q.sync[1]) begin
			d.stable = q.sync[2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.stable;
	// edge from the filtered level only, never from the first stage
	assign edgeSeen = (q.stable != d.stable) && (d.stable == riseSel);

	a_edge_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
		edgeSeen |=> (level == riseSel))
		else $error("edge without matching level");
endmodule : strobe_sync
`default_nettype wire

// ### hdl/parallel_port_ctrl.sv
// parallel handshake port: control/status register, strobes, port C drive
//
// Contract
// - handshake functions only in single-chip mode
// - control register read/write, top bit read-only
// - active strobe A edge sets flag
// - input modes: read ctrl, read latch clears
// - output handshake: read ctrl, write latch clears
// - irq when flag, enable, CCR I clear
// - one bit makes all port C open-drain
// - simple mode latches port C on edge
// - simple mode pulses strobe B after port B write
// - handshake bit set: direction picks in/out
// - direction ignored in simple mode
// - interlocked: strobe B held until edge
// - pulsed: strobe B active two cycles
// - pulse select ignored in simple mode
// - falling edge; output drive forced while high
// - rising edge; output drive forced while low
// - polarity bit sets strobe B active level
// - input handshake: edge drops B, read reasserts
// - output handshake: latch write drives, asserts B
// - port B write pulses B two periods
// - every edge in single-chip mode captures, flag set or not
`timescale 1ns/100ps
`default_nettype none
module parallel_port_ctrl
	import pio_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// parallel pins
	input wire logic strobeAInput,
	input wire logic [7:0] portCIn,
	output logic strobeBOutput,
	output pio_pkg::portc_pins_s portCPins,
	output logic [7:0] portBOut,
	// interrupt request
	output logic strobeAIrq
);
	import pio_pkg::*;

	localparam int unsigned PULSE_LEN = PULSE_CYC;
	initial begin
		if (PULSE_LEN < 1 || PULSE_LEN > 3) begin
			$error("pulse length out of range");
		end
	end

	typedef struct packed {
		logic [7:0] ctrl;
		logic [1:0] mode;
		logic armed;
		logic [7:0] latch;
		logic [7:0] outReg;
		logic [7:0] dir;
		logic [7:0] portB;
		logic stbActive;
		logic [1:0] pulseCnt;
		logic aphWrite;
		logic aphRead;
		logic [ADDR_W-1:0] aphAddr;
		logic [31:0] rdata;
		logic stbB;
		logic irq;
		portc_pins_s pins;
	} state_s;
	state_s q, d;

	logic staLevel;
	logic staEdge;

	strobe_sync u_sync (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.strobeAPin(strobeAInput),
		.riseSel(q.ctrl[BIT_EDGE]),
		.level(staLevel),
		.edgeSeen(staEdge)
	);

	// register read mux, used at the address edge to load the read data
	function automatic logic [31:0] readMux(input state_s s, input logic [ADDR_W-1:0] a,
			input logic [7:0] pinIn);
		logic [31:0] r;
		r = '0;
		case (a)
			OFF_CTRL: r[7:0] = s.ctrl;
			OFF_PORTC_LATCH: r[7:0] = s.latch;
			OFF_PORTB: r[7:0] = s.portB;
			// output handshake reads the output latch, the pins may float
			OFF_PORTC: r[7:0] = (s.ctrl[BIT_FULL_HANDSHAKE_SELECT] && s.ctrl[BIT_DIR]) ? s.outReg :
				((s.dir & s.outReg) | (~s.dir & pinIn));
			OFF_PORTC_DIR: r[7:0] = s.dir;
			OFF_MODE: r[1:0] = s.mode;
			default: r = '0;
		endcase
		return r;
	endfunction : readMux

	logic [7:0] portCSync1_q, portCSync2_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			portCSync1_q <= '0;
			portCSync2_q <= '0;
		end else begin
			portCSync1_q <= portCIn;
			portCSync2_q <= portCSync1_q;
		end
	end

	logic handshakeOn, outHs, startB, stopB, readLatch, writeLatch, writePortB;
	logic [7:0] driveMask;

	always_comb begin
		d = q;
		handshakeOn = q.mode[BIT_SINGLE] && q.ctrl[BIT_FULL_HANDSHAKE_SELECT];
		outHs = handshakeOn && q.ctrl[BIT_DIR];
		readLatch = q.aphRead && (q.aphAddr == OFF_PORTC_LATCH);
		writeLatch = q.aphWrite && (q.aphAddr == OFF_PORTC_LATCH);
		writePortB = q.aphWrite && (q.aphAddr == OFF_PORTB);
		startB = 1'b0;
		stopB = 1'b0;

		// data phase: writes land now; read data was already loaded at the address edge
		if (q.aphRead && q.aphAddr == OFF_CTRL && q.ctrl[BIT_FLAG]) begin
			d.armed = 1'b1; // first half of the clearing sequence
		end
		if (q.aphWrite) begin
			case (q.aphAddr)
				OFF_CTRL: d.ctrl = (q.ctrl & ~CTRL_WMASK) | (hwdata[7:0] & CTRL_WMASK);
				OFF_PORTC_LATCH: d.outReg = hwdata[7:0];
				OFF_PORTB: d.portB = hwdata[7:0];
				OFF_PORTC: d.outReg = hwdata[7:0];
				OFF_PORTC_DIR: d.dir = hwdata[7:0];
				OFF_MODE: d.mode = hwdata[1:0];
				default: d.mode = q.mode;
			endcase
		end

		// flag clear: the second access finishes the sequence
		if (q.armed && (outHs ? writeLatch : readLatch)) begin
			d.ctrl[BIT_FLAG] = 1'b0;
			d.armed = 1'b0;
		end

		// active edge in single-chip mode: capture always, set flag (set wins over clear)
		if (staEdge && q.mode[BIT_SINGLE]) begin
			d.latch = portCSync2_q;
			d.ctrl[BIT_FLAG] = 1'b1;
		end

		// strobe B sequencing
		if (!handshakeOn) begin
			startB = writePortB && q.mode[BIT_SINGLE];
		end else if (outHs) begin
			startB = writeLatch;
			stopB = staEdge;
		end else begin
			startB = readLatch;
			stopB = staEdge;
		end
		if (stopB) begin
			d.stbActive = 1'b0;
			d.pulseCnt = '0;
		end else if (startB) begin
			d.stbActive = 1'b1;
			d.pulseCnt = 2'(PULSE_LEN);
		end else if (q.pulseCnt != '0) begin
			d.pulseCnt = q.pulseCnt - 2'd1;
			// simple mode and pulsed handshake end by count; interlocked holds
			if (q.pulseCnt == 2'd1 && (!handshakeOn || q.ctrl[BIT_PULSE])) begin
				d.stbActive = 1'b0;
			end
		end
		if (!q.mode[BIT_SINGLE]) begin
			d.stbActive = 1'b0;
		end
		d.stbB = d.stbActive ? q.ctrl[BIT_POL] : ~q.ctrl[BIT_POL];

		// port C drive: output handshake forces drive while strobe A sits at the level just before its active edge
		driveMask = q.dir;
		if (outHs && (staLevel != q.ctrl[BIT_EDGE])) begin
			driveMask = 8'hff;
		end
		d.pins.out = d.outReg;
		// open-drain: drive only zeros
		d.pins.oe = q.ctrl[BIT_ODRAIN] ? (driveMask & ~d.outReg) : driveMask;

		d.irq = d.ctrl[BIT_FLAG] && d.ctrl[BIT_IRQEN] && !d.mode[BIT_CCR_I];

		// address phase capture
		d.aphWrite = hsel && hready && htrans[1] && hwrite;
		d.aphRead = hsel && hready && htrans[1] && !hwrite;
		d.aphAddr = haddr[ADDR_W-1:0];
		// read data must stand during the data phase, so load it at the address edge;
		// reading the next state forwards a write that lands on that same edge
		d.rdata = d.aphRead ? readMux(d, haddr[ADDR_W-1:0], portCSync2_q) : q.rdata;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.mode <= MODE_RESET;
			q.stbB <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// outputs straight from flops; zero-wait OKAY slave
	assign hrdata = q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign strobeBOutput = q.stbB;
	assign portCPins = q.pins;
	assign portBOut = q.portB;
	assign strobeAIrq = q.irq;

	a_flag_on_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(staEdge && q.mode[BIT_SINGLE]) |=> q.ctrl[BIT_FLAG])
		else $error("flag not set by edge");
	a_latch_capture: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(staEdge && q.mode[BIT_SINGLE]) |=> (q.latch == $past(portCSync2_q)))
		else $error("latch missed data");
	a_flag_readonly: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(q.aphWrite && q.aphAddr == OFF_CTRL && !staEdge && !q.armed)
		|=> (q.ctrl[BIT_FLAG] == $past(q.ctrl[BIT_FLAG])))
		else $error("flag written by software");
	a_irq_rule: assert property (@(posedge clk_sys) disable iff (!rst_b)
		q.irq == (q.ctrl[BIT_FLAG] && q.ctrl[BIT_IRQEN] && !q.mode[BIT_CCR_I]))
		else $error("irq mismatch");
	a_simple_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!handshakeOn && startB && !stopB)
		|=> q.stbActive [*2] ##1 !q.stbActive)
		else $error("strobe B pulse length wrong");
	a_polarity: assert property (@(posedge clk_sys) disable iff (!rst_b)
		##1 (q.stbB == ($past(d.stbActive) ? $past(q.ctrl[BIT_POL]) : !$past(q.ctrl[BIT_POL]))))
		else $error("strobe B level wrong");
	a_hold_b: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(handshakeOn && !q.ctrl[BIT_PULSE] && q.stbActive && !stopB
			&& q.mode[BIT_SINGLE] && $stable(q.ctrl))
		|=> q.stbActive)
		else $error("interlocked strobe dropped");
	a_edge_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(handshakeOn && staEdge) |=> !q.stbActive)
		else $error("strobe B not deasserted");
	a_no_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!q.mode[BIT_SINGLE] |=> !q.stbActive)
		else $error("strobe active outside single-chip");
	a_odrain: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(q.ctrl[BIT_ODRAIN]) |-> ((q.pins.oe & q.pins.out) == 8'h00))
		else $error("open-drain drives high");

	c_flag_cleared: cover property (@(posedge clk_sys) disable iff (!rst_b)
		q.ctrl[BIT_FLAG] ##1 !q.ctrl[BIT_FLAG]);
	c_out_hs: cover property (@(posedge clk_sys) disable iff (!rst_b)
		outHs && writeLatch ##[1:20] staEdge);
	c_in_hs: cover property (@(posedge clk_sys) disable iff (!rst_b)
		handshakeOn && !outHs && staEdge ##[1:20] readLatch);
	c_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) q.irq);
endmodule : parallel_port_ctrl
`default_nettype wire

// ### bench/par_dev.sv
// far-side parallel device: presents port C data and edges strobe A
`timescale 1ns/100ps
`default_nettype none
module par_dev (
	// clock
	input wire logic clk_sys,
	// strobe A and port C data towards the port
	output logic strobeA,
	output logic [7:0] dataOut
);
	initial begin
		strobeA = 1'b1;
		dataOut = 8'h00;
	end
	// park strobe A at the level just before its active edge
	task automatic idle(input logic rise);
		@(posedge clk_sys);
		strobeA <= ~rise;
	endtask : idle
	// data first, then the edge; released data shows its inverse, never a stale copy
	task automatic xfer(input logic [7:0] d, input logic rise);
		@(posedge clk_sys);
		dataOut <= d;
		repeat (4) @(posedge clk_sys);
		strobeA <= rise;
		repeat (6) @(posedge clk_sys);
		dataOut <= ~d;
		strobeA <= ~rise;
		repeat (6) @(posedge clk_sys);
	endtask : xfer
endmodule : par_dev
`default_nettype wire

// ### bench/tb_parallel_port_ctrl.sv
// self-checking bench for the parallel handshake port
`timescale 1ns/100ps
`default_nettype none
module tb_parallel_port_ctrl;
	import pio_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic strobeA;
	logic [7:0] portCIn;
	logic strobeB;
	portc_pins_s portCPins;
	logic [7:0] portBOut;
	logic irq;
	logic [31:0] rd;
	int c;
	int miscompares = 0;
	int n_checks = 0;
	// 50 ns period
	always #25 clk_sys = ~clk_sys;
	parallel_port_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .strobeAInput(strobeA),
		.portCIn(portCIn), .strobeBOutput(strobeB), .portCPins(portCPins),
		.portBOut(portBOut), .strobeAIrq(irq));
	par_dev dev (.clk_sys(clk_sys), .strobeA(strobeA), .dataOut(portCIn));
	// compare and count
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: exp %h got %h", $time, exp, got);
		end
	endtask : chk
	// single word transfer; waits on hready, never on a fixed count
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 99);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 99);
		rd = hrdata;
		// a bus that never answers counts as a mismatch
		if (n >= 99) begin
			miscompares++;
		end
	endtask : bus
	// cycles with strobe B at level act, sampled mid-cycle
	task automatic cnt(input logic act);
		c = 0;
		repeat (8) begin
			@(negedge clk_sys);
			c += (strobeB === act);
		end
	endtask : cnt
	task automatic t_reset;
		bus(0, OFF_CTRL, 0);
		chk(CTRL_RESET, rd);
		chk(1, strobeB);
		chk(0, irq);
		bus(1, OFF_CTRL, 32'hff);
		bus(0, OFF_CTRL, 0);
		chk(32'h7f, rd);
		bus(1, OFF_CTRL, 0);
		$display("done reset");
	endtask : t_reset
	// direction and pulse bits set but meaningless in simple mode
	task automatic t_simple;
		bus(1, OFF_MODE, 32'h1);
		bus(1, OFF_CTRL, 32'h4c);
		dev.xfer(8'ha5, 1'b0);
		bus(1, OFF_MODE, 32'h3);
		bus(0, OFF_CTRL, 0);
		chk(32'hcc, rd);
		chk(0, irq);
		bus(1, OFF_MODE, 32'h1);
		dev.xfer(8'h5a, 1'b0);
		chk(1, irq);
		bus(0, OFF_PORTC_LATCH, 0);
		chk(32'h5a, rd);
		bus(0, OFF_CTRL, 0);
		chk(32'h4c, rd);
		chk(0, irq);
		$display("done simple");
	endtask : t_simple
	task automatic t_portb;
		bus(1, OFF_CTRL, 32'h09);
		bus(1, OFF_PORTB, 32'h96);
		cnt(1'b1);
		chk(2, c);
		chk(8'h96, portBOut);
		$display("done portb");
	endtask : t_portb
	// output handshake, rising edge, strobe B active low
	task automatic t_ouths;
		bus(1, OFF_CTRL, 32'h1a);
		dev.idle(1'b1);
		bus(1, OFF_PORTC_LATCH, 32'h3c);
		repeat (10) @(posedge clk_sys);
		chk(0, strobeB);
		chk(8'h3c, portCPins.out);
		chk(8'hff, portCPins.oe);
		dev.xfer(8'h00, 1'b1);
		chk(1, strobeB);
		bus(0, OFF_CTRL, 0);
		chk(32'h9a, rd);
		bus(1, OFF_PORTC_LATCH, 32'h11);
		bus(0, OFF_CTRL, 0);
		chk(32'h1a, rd);
		dev.xfer(8'h00, 1'b1);
		bus(1, OFF_CTRL, 32'h1e);
		bus(1, OFF_PORTC_LATCH, 32'h22);
		cnt(1'b0);
		chk(2, c);
		$display("done ouths");
	endtask : t_ouths
	task automatic t_inhs;
		bus(1, OFF_CTRL, 32'h12);
		dev.xfer(8'h77, 1'b1);
		chk(1, strobeB);
		bus(0, OFF_PORTC_LATCH, 0);
		chk(32'h77, rd);
		repeat (2) @(posedge clk_sys);
		chk(0, strobeB);
		$display("done inhs");
	endtask : t_inhs
	// outside single-chip the edge must leave flag and latch alone
	task automatic t_mode;
		bus(0, OFF_CTRL, 0);
		bus(0, OFF_PORTC_LATCH, 0);
		bus(1, OFF_MODE, 0);
		dev.xfer(8'h55, 1'b1);
		bus(0, OFF_CTRL, 0);
		chk(32'h12, rd);
		bus(0, OFF_PORTC_LATCH, 0);
		chk(32'h77, rd);
		$display("done mode");
	endtask : t_mode
	task automatic test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_simple;
		t_portb;
		t_ouths;
		t_inhs;
		t_mode;
		test_done;
	end
	// tests need well under 1000 cycles; 4000 leaves ample margin
	initial begin
		#200000;
		miscompares++;
		test_done;
	end
endmodule : tb_parallel_port_ctrl
`default_nettype wire
